// ---- src/adcsoc_top.sv ----
// Purpose: Sample clock supervision, output coding, output enable and power states.
// Assumes: All inputs are synchronous to core_clk; sample_clk is sampled as a level.
// Notes:   Output pins carry separate value and enable; the board resolves Hi-Z.
`timescale 1ns/100ps
// Operation
// [RULE_01] Clock source stays at or below 80 Msps.
// [RULE_02] Unstabilized clock: 45-55 percent, halves 5.9 ns.
// [RULE_03] Stabilizer samples on rise, makes own fall.
// [RULE_04] Stabilizer accepts 40-60 percent input duty.
// [RULE_05] Stabilizer relocks after one hundred edges.
// [RULE_06] Clock source stays at or above 1 Msps.
// [RULE_07] Offset binary code, mid-scale is 10'h200.
// [RULE_08] Two's complement inverts the top bit.
// [RULE_09] Overrange raises flag and clamps the code.
// [RULE_10] Four-level pin selects format and stabilizer.
// [RULE_11] Output control high puts outputs Hi-Z.
// [RULE_12] Host avoids toggling output control at speed.
// [RULE_13] Power-down select low means normal operation.
// [RULE_14] Select and control high enter sleep.
// [RULE_15] Select high, control low enter nap.
// [RULE_16] Sleep and nap hold all outputs Hi-Z.
// [RULE_17] Unstabilized: track from fall, hold at rise.
// [RULE_18] One word per sample cycle after latency.
// [RULE_19] Host discards words until recovery ends.
module adcsoc_top #(
   parameter int unsigned SLEEP_WAKE_CYC = adcsoc_pkg::SLEEP_WAKE_CYC,
   parameter int unsigned LATENCY        = adcsoc_pkg::PIPE_LATENCY,
   parameter int unsigned DEPTH          = adcsoc_pkg::FIFO_DEPTH
) (
   // Clock, reset and enable
   input  wire logic               core_clk,
   input  wire logic               rstn,
   input  wire logic               ce,
   // Sample clock and conversion result
   input  wire logic               sample_clk,
   input  wire logic signed [11:0] ain_level,
   // Control pins
   input  wire logic [1:0]         mode_level,
   input  wire logic               oe_n,
   input  wire logic               power_down_select,
   // Output pins
   output logic [9:0]              sample_code,
   output logic                    sample_code_oe,
   output logic                    overrange_flag,
   output logic                    overrange_flag_oe,
   // Status
   output logic                    track_phase,
   output logic                    stab_locked,
   output logic                    data_valid,
   output logic                    clk_fault,
   output logic                    stab_on,
   output logic                    twos_format,
   output logic [1:0]              power_state
);
   localparam int PW = adcsoc_pkg::PER_W;

   // ==========================================================================
   // Clock supervision
   logic          clk_d, next_clk_d;
   logic [PW-1:0] since_rise, next_since_rise;
   logic [PW-1:0] hi_cnt, next_hi_cnt;
   logic [PW-1:0] hi_len, next_hi_len;
   logic [PW-1:0] period, next_period;
   logic [6:0]    lock_cnt, next_lock_cnt;
   logic          next_stab_locked, next_clk_fault, next_track_phase;
   logic          rise, fall, stopped;
   logic [PW-1:0] per_now;
   adcsoc_pkg::adcsoc_cfg_t cfg;

   always_comb begin
      rise             = sample_clk && !clk_d;
      fall             = !sample_clk && clk_d;
      cfg              = adcsoc_pkg::mode_decode(mode_level);         // [RULE_10]
      stopped          = (since_rise >= PW'(adcsoc_pkg::MAX_PER_CYC));
      per_now          = since_rise + 1'b1;
      next_clk_d       = sample_clk;
      next_since_rise  = rise ? '0 : (stopped ? since_rise : since_rise + 1'b1);
      next_hi_cnt      = rise ? PW'(1) : (sample_clk && !stopped ? hi_cnt + 1'b1 : hi_cnt);
      next_hi_len      = fall ? hi_cnt : hi_len;
      next_period      = rise ? per_now : period;
      next_lock_cnt    = lock_cnt;
      next_stab_locked = stab_locked;
      next_clk_fault   = clk_fault;
      if (!stab_on || stopped) begin
         next_lock_cnt    = '0;                                       // [RULE_05]
         next_stab_locked = 1'b0;
      end else if (rise && !stab_locked) begin
         next_lock_cnt    = lock_cnt + 1'b1;
         next_stab_locked = (lock_cnt == 7'(adcsoc_pkg::RELOCK_EDGES - 1)); // [RULE_05]
      end
      if (stopped) begin
         next_clk_fault = 1'b1;                                       // [RULE_06]
      end else if (rise) begin
         next_clk_fault = per_now < PW'(adcsoc_pkg::MIN_PER_CYC);     // [RULE_01]
         if (stab_on) begin
            next_clk_fault = next_clk_fault || !adcsoc_pkg::duty_ok(hi_len, per_now,
               adcsoc_pkg::DUTY_STAB_LO, adcsoc_pkg::DUTY_STAB_HI);   // [RULE_04]
         end else begin
            next_clk_fault = next_clk_fault || !adcsoc_pkg::duty_ok(hi_len, per_now,
               adcsoc_pkg::DUTY_NOM_LO, adcsoc_pkg::DUTY_NOM_HI)      // [RULE_02]
               || hi_len < PW'(adcsoc_pkg::MIN_HALF_CYC)
               || (per_now - hi_len) < PW'(adcsoc_pkg::MIN_HALF_CYC);
         end
      end
      if (stab_on) begin
         next_track_phase = !rise && (per_now >= (period >> 1));      // [RULE_03]
      end else begin
         next_track_phase = !sample_clk;                              // [RULE_17]
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         clk_d       <= 1'b0;
         since_rise  <= '0;
         hi_cnt      <= '0;
         hi_len      <= '0;
         period      <= '0;
         lock_cnt    <= '0;
         stab_locked <= 1'b0;
         clk_fault   <= 1'b0;
         track_phase <= 1'b0;
         stab_on     <= 1'b0;
         twos_format <= 1'b0;
      end else if (ce) begin
         clk_d       <= next_clk_d;
         since_rise  <= next_since_rise;
         hi_cnt      <= next_hi_cnt;
         hi_len      <= next_hi_len;
         period      <= next_period;
         lock_cnt    <= next_lock_cnt;
         stab_locked <= next_stab_locked;
         clk_fault   <= next_clk_fault;
         track_phase <= next_track_phase;
         stab_on     <= cfg.stab;
         twos_format <= cfg.twos;
      end
   end

   // ==========================================================================
   // Power states
   adcsoc_pkg::adcsoc_pwr_t pstate, next_pstate;
   logic [31:0] wake_cnt, next_wake_cnt;
   logic        wake_sleep, next_wake_sleep;

   always_comb begin
      next_pstate     = pstate;
      next_wake_cnt   = wake_cnt;
      next_wake_sleep = wake_sleep;
      unique case (pstate)
         adcsoc_pkg::PWR_RUN, adcsoc_pkg::PWR_WAKE: begin
            if (power_down_select) begin
               next_pstate = oe_n ? adcsoc_pkg::PWR_SLEEP : adcsoc_pkg::PWR_NAP; // [RULE_14] [RULE_15]
            end else if (pstate == adcsoc_pkg::PWR_WAKE) begin
               if (wake_cnt == '0) begin
                  next_pstate = adcsoc_pkg::PWR_RUN;
               end else if (wake_sleep || rise) begin
                  next_wake_cnt = wake_cnt - 1'b1;
               end
            end
         end
         adcsoc_pkg::PWR_NAP, adcsoc_pkg::PWR_SLEEP: begin
            if (!power_down_select) begin
               next_pstate     = adcsoc_pkg::PWR_WAKE;                 // [RULE_13]
               next_wake_sleep = (pstate == adcsoc_pkg::PWR_SLEEP);
               next_wake_cnt   = next_wake_sleep ? SLEEP_WAKE_CYC      // [RULE_14]
                                 : 32'(adcsoc_pkg::NAP_WAKE_EDGES);    // [RULE_15]
            end else if (pstate == adcsoc_pkg::PWR_NAP && oe_n) begin
               next_pstate = adcsoc_pkg::PWR_SLEEP;
            end else if (pstate == adcsoc_pkg::PWR_SLEEP && !oe_n) begin
               next_pstate = adcsoc_pkg::PWR_NAP;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pstate     <= adcsoc_pkg::PWR_RUN;
         wake_cnt   <= '0;
         wake_sleep <= 1'b0;
      end else if (ce) begin
         pstate     <= next_pstate;
         wake_cnt   <= next_wake_cnt;
         wake_sleep <= next_wake_sleep;
      end
   end

   // ==========================================================================
   // Data path
   adcsoc_pkg::adcsoc_word_t conv_word, cap, next_cap, fifo_word;
   logic        cap_valid, next_cap_valid;
   logic [3:0]  fill, next_fill;
   logic        in_ready, out_valid, pop, flush, pwr_off, out_en;
   logic [9:0]  next_code;
   logic        next_ovr, next_data_valid;

   adcsoc_coder u_coder (
      .ain_level (ain_level),
      .twos      (twos_format),
      .word      (conv_word)
   );

   adcsoc_fifo #(
      .W (adcsoc_pkg::CODE_W + 1),
      .D (DEPTH)
   ) u_fifo (
      .core_clk  (core_clk),
      .rstn      (rstn),
      .ce        (ce),
      .flush     (flush),
      .in_valid  (cap_valid),
      .in_ready  (in_ready),
      .in_data   (cap),
      .out_valid (out_valid),
      .out_ready (pop),
      .out_data  (fifo_word)
   );

   always_comb begin
      pwr_off        = (pstate == adcsoc_pkg::PWR_NAP) || (pstate == adcsoc_pkg::PWR_SLEEP);
      flush          = pwr_off;
      out_en         = !oe_n && !pwr_off;                              // [RULE_11] [RULE_16]
      pop            = rise && out_valid && (fill == 4'(LATENCY));     // [RULE_18]
      next_cap       = cap;
      next_cap_valid = cap_valid && !in_ready;
      if (rise && !(cap_valid && !in_ready)) begin
         next_cap       = conv_word;
         next_cap_valid = !pwr_off;
      end
      next_fill = fill;
      if (pwr_off) begin
         next_fill = '0;
      end else if (cap_valid && in_ready && fill != 4'(LATENCY)) begin
         next_fill = fill + 1'b1;
      end
      next_code       = pop ? fifo_word.code : sample_code;
      next_ovr        = pop ? fifo_word.ovr : overrange_flag;
      next_data_valid = (pstate == adcsoc_pkg::PWR_RUN) && (fill == 4'(LATENCY))
                        && (!stab_on || stab_locked);                  // [RULE_19]
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cap               <= '0;
         cap_valid         <= 1'b0;
         fill              <= '0;
         sample_code       <= '0;
         overrange_flag    <= 1'b0;
         sample_code_oe    <= 1'b0;
         overrange_flag_oe <= 1'b0;
         data_valid        <= 1'b0;
         power_state       <= 2'h0;
      end else if (ce) begin
         cap               <= next_cap;
         cap_valid         <= next_cap_valid;
         fill              <= next_fill;
         sample_code       <= next_code;
         overrange_flag    <= next_ovr;
         sample_code_oe    <= out_en;
         overrange_flag_oe <= out_en;
         data_valid        <= next_data_valid;
         power_state       <= next_pstate;
      end
   end

   // ==========================================================================
   // Checks
   logic [7:0] edges_run;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         edges_run <= '0;
      end else if (ce) begin
         edges_run <= (!stab_on || stopped) ? 8'h00 : (rise && edges_run != 8'hff ? edges_run + 1'b1 : edges_run);
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   a_oe_hiz:     assert property (ce && oe_n |=> !sample_code_oe && !overrange_flag_oe) // [RULE_11]
      else $error("Outputs driven while output control high.");
   a_lowpwr_hiz: assert property (ce && pwr_off |=> !sample_code_oe && !overrange_flag_oe) // [RULE_16]
      else $error("Outputs driven in sleep or nap.");
   a_sleep_entry: assert property (ce && pstate == adcsoc_pkg::PWR_RUN && power_down_select && oe_n // [RULE_14]
      |=> pstate == adcsoc_pkg::PWR_SLEEP)
      else $error("Sleep not entered.");
   a_nap_entry:  assert property (ce && pstate == adcsoc_pkg::PWR_RUN && power_down_select && !oe_n // [RULE_15]
      |=> pstate == adcsoc_pkg::PWR_NAP)
      else $error("Nap not entered.");
   a_run_stays:  assert property (ce && pstate == adcsoc_pkg::PWR_RUN && !power_down_select // [RULE_13]
      |=> pstate == adcsoc_pkg::PWR_RUN)
      else $error("Left normal operation with select low.");
   a_relock_edges: assert property ($rose(stab_locked) |-> edges_run >= 8'h64) // [RULE_05]
      else $error("Stabilizer locked too early.");
   a_ob_mid:     assert property (!twos_format && ain_level == 12'sh000 |-> conv_word.code == 10'h200) // [RULE_07]
      else $error("Offset binary mid-scale wrong.");
   a_twos_mid:   assert property (twos_format && ain_level == 12'sh000 |-> conv_word.code == 10'h000) // [RULE_08]
      else $error("Two's complement zero wrong.");
   a_ovr_clamp:  assert property (ain_level > 12'sh1ff |-> conv_word.ovr // [RULE_09]
      && conv_word.code == (twos_format ? 10'h1ff : 10'h3ff))
      else $error("Overrange not clamped.");
   a_mode_third: assert property (ce && mode_level == 2'h1 |=> stab_on && !twos_format) // [RULE_10]
      else $error("Mode pin decode wrong.");
   a_track_fall: assert property (ce && !stab_on && fall |=> track_phase) // [RULE_17]
      else $error("Tracking not started at fall.");
   a_stab_hold:  assert property (ce && stab_on && rise |=> !track_phase) // [RULE_03]
      else $error("Stabilized hold not at rise.");
   a_pop_rise:   assert property (ce && rise && fill == 4'(LATENCY) |-> pop) // [RULE_18]
      else $error("Primed pipeline skipped a sample edge.");

   c_sleep:  cover property (pstate == adcsoc_pkg::PWR_SLEEP);
   c_nap_up: cover property (pstate == adcsoc_pkg::PWR_WAKE && next_pstate == adcsoc_pkg::PWR_RUN);
   c_lock:   cover property ($rose(stab_locked));
   c_ovr:    cover property (pop && fifo_word.ovr);

endmodule : adcsoc_top

// ---- inc/adcsoc_pkg.sv ----
// Purpose: Shared constants, types and helpers for the sample output control block.
// Assumes: Core clock of 250 MHz; the sample clock arrives as a synchronous level.
// Notes:   Times are kept in their own unit and converted to core cycles here.
package adcsoc_pkg;

   // ==========================================================================
   // Timing
   localparam int CLK_PS         = 4000;
   localparam int MIN_HALF_PS    = 5900;
   localparam int MIN_HALF_CYC   = (MIN_HALF_PS + CLK_PS - 1) / CLK_PS;
   localparam int MIN_PER_PS     = 12500;
   localparam int MIN_PER_CYC    = (MIN_PER_PS + CLK_PS - 1) / CLK_PS;
   localparam int MAX_PER_PS     = 1000000;
   localparam int MAX_PER_CYC    = MAX_PER_PS / CLK_PS;
   localparam int SLEEP_WAKE_NS  = 1000000;
   localparam int SLEEP_WAKE_CYC = (SLEEP_WAKE_NS * 1000) / CLK_PS;
   localparam int RELOCK_EDGES   = 100;
   localparam int NAP_WAKE_EDGES = 100;
   localparam int DUTY_NOM_LO    = 45;
   localparam int DUTY_NOM_HI    = 55;
   localparam int DUTY_STAB_LO   = 40;
   localparam int DUTY_STAB_HI   = 60;
   localparam int PIPE_LATENCY   = 5;
   localparam int FIFO_DEPTH     = 8;
   localparam int PER_W          = 9;

   // ==========================================================================
   // Codes
   localparam int CODE_W                 = 10;
   localparam logic signed [11:0] AIN_MAX = 12'sh1ff;
   localparam logic signed [11:0] AIN_MIN = 12'she00;
   localparam logic [9:0] CODE_MID        = 10'h200;

   typedef struct packed {
      logic       ovr;
      logic [9:0] code;
   } adcsoc_word_t;

   typedef struct packed {
      logic twos;
      logic stab;
   } adcsoc_cfg_t;

   typedef enum logic [1:0] {
      MODE_GND     = 2'h0,
      MODE_THIRD   = 2'h1,
      MODE_TWO3RD  = 2'h2,
      MODE_SUPPLY  = 2'h3
   } adcsoc_mode_t;

   typedef enum logic [1:0] {
      PWR_RUN   = 2'h0,
      PWR_NAP   = 2'h1,
      PWR_SLEEP = 2'h2,
      PWR_WAKE  = 2'h3
   } adcsoc_pwr_t;

   // Four-level pin to format and stabilizer setting.
   function automatic adcsoc_cfg_t mode_decode(input logic [1:0] lvl);
      adcsoc_cfg_t c;
      c.twos = lvl[1];
      c.stab = lvl[1] ^ lvl[0];
      return c;
   endfunction : mode_decode

   // True when the high time is within lo..hi percent of the period.
   function automatic logic duty_ok(input logic [PER_W-1:0] hi_len, input logic [PER_W-1:0] per,
                                    input int lo, input int hi);
      int h;
      int p;
      h = int'(hi_len) * 100;
      p = int'(per);
      return (h >= p * lo) && (h <= p * hi);
   endfunction : duty_ok

endpackage : adcsoc_pkg

// ---- src/adcsoc_fifo.sv ----
// Purpose: Word FIFO between the capture stage and the output pins.
// Assumes: Single clock; flush empties it in one cycle.
// Notes:   Honest full and empty; stall on either side is allowed.
`timescale 1ns/100ps
module adcsoc_fifo #(
   parameter int W = 11,
   parameter int D = 8
) (
   // Clock and reset
   input  wire logic         core_clk,
   input  wire logic         rstn,
   input  wire logic         ce,
   input  wire logic         flush,
   // Fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // Drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);
   localparam int CW = $clog2(D + 1);

   logic [W-1:0]  mem [D];
   logic [AW-1:0] wr_ptr, next_wr_ptr;
   logic [AW-1:0] rd_ptr, next_rd_ptr;
   logic [CW-1:0] count,  next_count;
   logic          do_push, do_pop;

   // ==========================================================================
   // Next state
   always_comb begin
      in_ready    = (count != CW'(D));
      out_valid   = (count != '0);
      out_data    = mem[rd_ptr];
      do_push     = in_valid && in_ready && !flush;
      do_pop      = out_valid && out_ready && !flush;
      next_wr_ptr = do_push ? ((wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
      next_rd_ptr = do_pop ? ((rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
      next_count  = count + CW'(do_push) - CW'(do_pop);
      if (flush) begin
         next_wr_ptr = '0;
         next_rd_ptr = '0;
         next_count  = '0;
      end
   end

   // ==========================================================================
   // Registers
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else if (ce) begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end

   always_ff @(posedge core_clk) begin
      if (ce && do_push) begin
         mem[wr_ptr] <= in_data;
      end
   end

endmodule : adcsoc_fifo

// ---- src/adcsoc_coder.sv ----
// Purpose: Clamp the conversion result and map it to the selected output format.
// Assumes: Input is the signed result in steps of one code, zero at mid-scale.
// Notes:   Purely combinational.
`timescale 1ns/100ps
module adcsoc_coder (
   // Conversion result
   input  wire logic signed [11:0] ain_level,
   input  wire logic               twos,
   // Formatted word
   output adcsoc_pkg::adcsoc_word_t word
);
   logic signed [11:0] clamped;
   logic [9:0]         offs;

   always_comb begin
      word.ovr = (ain_level > adcsoc_pkg::AIN_MAX) || (ain_level < adcsoc_pkg::AIN_MIN); // [RULE_09]
      clamped  = ain_level;
      if (ain_level > adcsoc_pkg::AIN_MAX) begin
         clamped = adcsoc_pkg::AIN_MAX;
      end else if (ain_level < adcsoc_pkg::AIN_MIN) begin
         clamped = adcsoc_pkg::AIN_MIN;
      end
      offs      = clamped[9:0] ^ adcsoc_pkg::CODE_MID;              // [RULE_07]
      word.code = twos ? (offs ^ adcsoc_pkg::CODE_MID) : offs;      // [RULE_08]
   end

endmodule : adcsoc_coder

// ---- testbench/adcsoc_capture.sv ----
// Purpose: Capturing logic that stands on the far side of the output pins.
// Assumes: Pins are resolved here from value and enable.
// Notes:   Undriven pins show the inverse of the last captured value.
`timescale 1ns/100ps
module adcsoc_capture (
   // Clock and reset
   input  wire logic                core_clk,
   input  wire logic                rstn,
   // Pins and status
   input  wire logic [9:0]          sample_code,
   input  wire logic                sample_code_oe,
   input  wire logic                overrange_flag,
   input  wire logic                overrange_flag_oe,
   input  wire logic                data_valid,
   // Captured word
   output adcsoc_pkg::adcsoc_word_t seen_word
);
   // ==========================================================================
   // Pin resolution and capture
   adcsoc_pkg::adcsoc_word_t bus_word;
   adcsoc_pkg::adcsoc_word_t next_seen_word;
   always_comb begin
      bus_word.code  = sample_code_oe ? sample_code : ~seen_word.code;
      bus_word.ovr   = overrange_flag_oe ? overrange_flag : ~seen_word.ovr;
      next_seen_word = seen_word;
      if (data_valid && sample_code_oe && overrange_flag_oe) begin
         next_seen_word = bus_word;
      end
   end
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) seen_word <= '0;
      else seen_word <= next_seen_word;
   end
endmodule : adcsoc_capture

// ---- testbench/testbench.sv ----
// Purpose: Self-checking bench for the sample output control block.
// Assumes: Sample clock is made here as a level synchronous to core_clk.
// Notes:   Sleep wake time is shortened to 20 core cycles.
`timescale 1ns/100ps
module testbench;
   // ==========================================================================
   // Signals
   logic                     core_clk, rstn, ce, sample_clk, oe_n, power_down_select, clk_run;
   logic signed [11:0]       ain_level;
   logic [1:0]               mode_level, power_state;
   logic [9:0]               sample_code;
   logic                     sample_code_oe, overrange_flag, overrange_flag_oe, track_phase;
   logic                     stab_locked, data_valid, clk_fault, stab_on, twos_format;
   adcsoc_pkg::adcsoc_word_t seen_word;
   int                       bad_count, checks, per, hi, ph;
   localparam logic [7:0]    MODE_TAB = 8'hb4;
   // ==========================================================================
   // Design and capturing logic
   adcsoc_top #(.SLEEP_WAKE_CYC(20)) adcsoc_top_inst (.core_clk(core_clk), .rstn(rstn), .ce(ce),
      .sample_clk(sample_clk), .ain_level(ain_level), .mode_level(mode_level), .oe_n(oe_n),
      .power_down_select(power_down_select), .sample_code(sample_code), .sample_code_oe(sample_code_oe),
      .overrange_flag(overrange_flag), .overrange_flag_oe(overrange_flag_oe), .track_phase(track_phase),
      .stab_locked(stab_locked), .data_valid(data_valid), .clk_fault(clk_fault), .stab_on(stab_on),
      .twos_format(twos_format), .power_state(power_state));
   adcsoc_capture adcsoc_capture_inst (.core_clk(core_clk), .rstn(rstn), .sample_code(sample_code),
      .sample_code_oe(sample_code_oe), .overrange_flag(overrange_flag),
      .overrange_flag_oe(overrange_flag_oe), .data_valid(data_valid), .seen_word(seen_word));
   // ==========================================================================
   // Clocks
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      ph         <= (ph >= per - 1) ? 0 : ph + 1;
      sample_clk <= clk_run && (ph < hi);
   end
   // ==========================================================================
   // Tasks
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic cycles(input int n);
      repeat (n) @(posedge core_clk);
   endtask : cycles
   function automatic logic [1:0] probe(input int k);
      case (k)
         0: return power_state;
         1: return {1'b0, stab_locked};
         2: return {1'b0, data_valid};
         default: return {1'b0, clk_fault};
      endcase
   endfunction : probe
   task automatic wait_for(input string name, input int k, input logic [1:0] exp, input int bound);
      int i;
      for (i = 0; i < bound && probe(k) !== exp; i++) cycles(1);
      check(name, 16'(probe(k)), 16'(exp));
      if (probe(k) !== exp) report_and_stop();
   endtask : wait_for
   task automatic set_clk(input int p, input int h, input logic [1:0] m);
      @(posedge core_clk);
      per        <= p;
      hi         <= h;
      mode_level <= m;
   endtask : set_clk
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : report_and_stop
   // ==========================================================================
   // Tests
   initial begin : main
      int               m, v, c;
      logic [10:0]      exp;
      int               lv[7] = '{0, 1, -1, 511, -512, 700, -700};
      {rstn, ce, oe_n, power_down_select, clk_run} = '0;
      {ain_level, mode_level, bad_count, checks} = '0;
      per = 8;
      hi  = 4;
      cycles(4);
      @(posedge core_clk);
      {rstn, ce, clk_run} <= 3'h7;
      for (m = 0; m < 4; m++) begin
         set_clk(8, 4, m[1:0]);
         cycles(3);
         check("mode", {14'h0, twos_format, stab_on}, 16'(MODE_TAB[2*m +: 2]));
      end
      $display("test mode done");
      for (m = 0; m < 4; m += 3) begin
         set_clk(8, 4, m[1:0]);
         foreach (lv[i]) begin
            @(posedge core_clk);
            ain_level <= 12'(lv[i]);
            cycles(120);
            v   = lv[i];
            c   = (v > 511) ? 511 : (v < -512) ? -512 : v;
            exp = {v != c, 10'(c + 512) ^ (m == 3 ? 10'h200 : 10'h000)};
            check("code", 16'(seen_word), 16'(exp));
         end
      end
      $display("test code done");
      @(posedge core_clk) oe_n <= 1'b1;
      cycles(3);
      check("oe", {14'h0, sample_code_oe, overrange_flag_oe}, 16'h0);
      @(posedge core_clk) power_down_select <= 1'b1;
      wait_for("sleep", 0, adcsoc_pkg::PWR_SLEEP, 10);
      @(posedge core_clk) oe_n <= 1'b0;
      wait_for("nap", 0, adcsoc_pkg::PWR_NAP, 10);
      cycles(3);
      check("hiz", {14'h0, sample_code_oe, overrange_flag_oe}, 16'h0);
      @(posedge core_clk) power_down_select <= 1'b0;
      wait_for("wake", 0, adcsoc_pkg::PWR_WAKE, 10);
      cycles(600);
      check("nap_hold", 16'(power_state), 16'(adcsoc_pkg::PWR_WAKE));
      wait_for("run", 0, adcsoc_pkg::PWR_RUN, 600);
      wait_for("valid", 2, 2'h1, 200);
      @(posedge core_clk) {oe_n, power_down_select} <= 2'h3;
      wait_for("sleep2", 0, adcsoc_pkg::PWR_SLEEP, 10);
      @(posedge core_clk) power_down_select <= 1'b0;
      wait_for("wake2", 0, adcsoc_pkg::PWR_WAKE, 10);
      cycles(10);
      check("sleep_hold", 16'(power_state), 16'(adcsoc_pkg::PWR_WAKE));
      wait_for("sleep_run", 0, adcsoc_pkg::PWR_RUN, 40);
      @(posedge core_clk) oe_n <= 1'b0;
      $display("test power done");
      set_clk(10, 3, 2'h0);
      wait_for("duty_bad", 3, 2'h1, 100);
      set_clk(10, 4, 2'h1);
      wait_for("duty_stab", 3, 2'h0, 100);
      wait_for("lock", 1, 2'h1, 1300);
      set_clk(2, 1, 2'h0);
      wait_for("fast", 3, 2'h1, 50);
      set_clk(8, 4, 2'h0);
      wait_for("good", 3, 2'h0, 100);
      @(posedge core_clk) clk_run <= 1'b0;
      wait_for("stop", 3, 2'h1, 400);
      check("track", 16'(track_phase), 16'h1);
      $display("test clock done");
      report_and_stop();
   end
endmodule : testbench
